// [src/bpmc_power_ctrl.sv]
// backup power mode control: selection decode, supply switch-over state,
// battery switch and low flags, timestamp capture, interface blocking.
// assumes analog comparator outputs asynchronous to core_clk_i, a running
// time counter on the same clock, and a host serial front end beside it.
// REC_CYCLES sets how long the power-fail comparator stays off after the return to main.
//
// Local design decisions: the register offsets and the plain strobed port.
`timescale 1ns/1ps
`include "bpmc_defs.svh"

module bpmc_power_ctrl #(
    parameter int unsigned REC_CYCLES = `BPMC_REC_CYCLES
) (
    input wire logic core_clk_i,
    input wire logic rst_i,
    // register port
    input wire logic [`BPMC_ADDR_W-1:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [31:0] reg_rdata_o,
    // analog comparator results, asynchronous
    input wire logic vdd_below_bat_i,
    input wire logic vdd_below_thr_i,
    input wire logic bat_below_low_i,
    input wire logic pfi_below_ref_i,
    // current time and date from the counter chain
    input wire logic [`BPMC_TIME_W-1:0] time_now_i,
    // serial interface gating
    input wire logic [3:0] serial_in_i,
    output logic [3:0] serial_in_gated_o,
    input wire logic [3:0] serial_out_i,
    input wire logic [3:0] serial_oe_i,
    output logic [3:0] serial_out_o,
    output logic [3:0] serial_oe_o,
    // power outputs
    output logic on_backup_o,
    output logic power_fail_out_o,
    output logic power_fail_out_oe_o,
    output logic ts_capture_o,
    output logic irq_o
);
    // -------------------------------------------------------------------------
    // comparator synchronisers
    // -------------------------------------------------------------------------
    // pfi, low bat, below thr, below bat
    logic [3:0] sync_a;
    logic [3:0] sync_b;

    logic [3:0] next_sync_a;
    logic [3:0] next_sync_b;

    // first stage feeds only the second stage
    always_comb begin
        next_sync_a = {pfi_below_ref_i, bat_below_low_i, vdd_below_thr_i, vdd_below_bat_i};
        next_sync_b = sync_a;
    end

    // two flops before any logic reads a pin
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            sync_a <= 4'h0;
            sync_b <= 4'h0;
        end else begin
            sync_a <= next_sync_a;
            sync_b <= next_sync_b;
        end
    end

    // -------------------------------------------------------------------------
    // helper modules
    // -------------------------------------------------------------------------
    // bundle shared by the helpers
    bpmc_cmp_if cmp ();
    logic [7:0] ctrl;

    assign cmp.vdd_lt_bat = sync_b[0];
    assign cmp.vdd_lt_thr = sync_b[1];
    assign cmp.bat_low = sync_b[2];
    assign cmp.pfi_low = sync_b[3];
    assign cmp.sel = ctrl[`BPMC_CTRL_SEL_MSB:`BPMC_CTRL_SEL_LSB];

    // mode and enables
    bpmc_func_decode u_decode (
        .cmp(cmp)
    );

    // failure condition per mode
    bpmc_fail_judge u_judge (
        .cmp(cmp)
    );

    // -------------------------------------------------------------------------
    // supply state machine
    // -------------------------------------------------------------------------
    bpmc_pkg::bpmc_state_t state;
    bpmc_pkg::bpmc_state_t next_state;

    // recovery clock count
    logic [31:0] rec_cnt;
    logic [31:0] next_rec_cnt;
    // strobes at state edges
    logic enter_backup;
    logic leave_backup;

    // recovery keeps the comparator off for a while so a bouncing supply
    // does not toggle the power-fail pin before it settles
    always_comb begin
        next_state = state;
        next_rec_cnt = rec_cnt;
        enter_backup = 1'b0;
        leave_backup = 1'b0;
        case (state)
            bpmc_pkg::BPMC_ST_MAIN: begin
                if (cmp.pfail_cond) begin
                    next_state = bpmc_pkg::BPMC_ST_BACKUP;
                    enter_backup = 1'b1;
                end
            end
            bpmc_pkg::BPMC_ST_BACKUP: begin
                if (!cmp.pfail_cond) begin
                    next_state = bpmc_pkg::BPMC_ST_RECOVER;
                    next_rec_cnt = 32'h0;
                    leave_backup = 1'b1;
                end
            end
            // new failure beats the count
            bpmc_pkg::BPMC_ST_RECOVER: begin
                if (cmp.pfail_cond) begin
                    next_state = bpmc_pkg::BPMC_ST_BACKUP;
                    enter_backup = 1'b1;
                end else if (rec_cnt >= REC_CYCLES - 1) begin
                    next_state = bpmc_pkg::BPMC_ST_MAIN;
                end else begin
                    next_rec_cnt = rec_cnt + 32'h1;
                end
            end
            default: next_state = bpmc_pkg::BPMC_ST_MAIN;
        endcase
    end

    // state and count registers
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            state <= bpmc_pkg::BPMC_ST_MAIN;
            rec_cnt <= 32'h0;
        end else begin
            state <= next_state;
            rec_cnt <= next_rec_cnt;
        end
    end

    // only backup blocks the host
    logic backup;
    assign backup = (state == bpmc_pkg::BPMC_ST_BACKUP);

    // -------------------------------------------------------------------------
    // registers, flags, timestamp
    // -------------------------------------------------------------------------
    logic bsf;
    logic battery_low_flag;
    logic [`BPMC_IRQ_W-1:0] irq_stat;
    logic [`BPMC_IRQ_W-1:0] irq_mask;
    logic [`BPMC_TIME_W-1:0] ts_time;
    logic [31:0] rdata;
    logic ts_pulse;

    // next values
    logic [7:0] next_ctrl;
    logic next_bsf;
    logic next_blf;
    logic [`BPMC_IRQ_W-1:0] next_irq_stat;
    logic [`BPMC_IRQ_W-1:0] next_irq_mask;
    logic [`BPMC_TIME_W-1:0] next_ts_time;
    logic [31:0] next_rdata;
    logic next_ts_pulse;

    // gated host strobes
    logic wr_ok;
    logic rd_ok;
    // events of this cycle
    logic [`BPMC_IRQ_W-1:0] irq_evt;

    // host accesses are dropped entirely while on backup
    assign wr_ok = reg_wr_i & ~backup;
    assign rd_ok = reg_rd_i & ~backup;

    // host writes and power events
    always_comb begin
        next_ctrl = ctrl;
        next_bsf = bsf;
        next_irq_mask = irq_mask;
        next_ts_time = ts_time;
        next_ts_pulse = 1'b0;
        next_rdata = 32'h0;
        // low-battery flag simply tracks the comparator while enabled
        next_blf = cmp.func.batlow_en & cmp.bat_low;
        // unmapped writes are dropped
        if (wr_ok) begin
            case (reg_addr_i)
                `BPMC_OFF_CTRL: next_ctrl = reg_wdata_i[7:0];
                `BPMC_OFF_STATUS: begin
                    if (reg_wdata_i[`BPMC_ST_CLR_BSF_BIT]) begin
                        next_bsf = 1'b0;
                    end
                end
                `BPMC_OFF_IRQ_MASK: next_irq_mask = reg_wdata_i[`BPMC_IRQ_W-1:0];
                default: next_ctrl = ctrl;
            endcase
        end
        // set after clear: an entry in the clear cycle is kept
        if (enter_backup) begin
            next_bsf = 1'b1;
            if (ctrl[`BPMC_CTRL_BATTERY_SWITCH_TIMESTAMP_ENABLE_BIT]) begin
                next_ts_time = time_now_i;
                next_ts_pulse = 1'b1;
            end
        end
        // data stand one cycle, else zero
        if (rd_ok) begin
            case (reg_addr_i)
                `BPMC_OFF_CTRL: next_rdata = {24'h0, ctrl};
                `BPMC_OFF_STATUS: next_rdata = {28'h0, power_fail_out_o, backup, battery_low_flag, bsf};
                `BPMC_OFF_IRQ_STAT: next_rdata = {29'h0, irq_stat};
                `BPMC_OFF_IRQ_MASK: next_rdata = {29'h0, irq_mask};
                `BPMC_OFF_TS_TIME: next_rdata = ts_time;
                default: next_rdata = 32'h0;
            endcase
        end
    end

    // sticky events: a read clears, a coinciding event wins
    always_comb begin
        irq_evt = '0;
        irq_evt[`BPMC_IRQ_SWITCH_BIT] = enter_backup & ctrl[`BPMC_CTRL_BIE_BIT];
        irq_evt[`BPMC_IRQ_BATLOW_BIT] = next_blf & ~battery_low_flag;
        irq_evt[`BPMC_IRQ_RETURN_BIT] = leave_backup;
        next_irq_stat = irq_stat;
        if (rd_ok && reg_addr_i == `BPMC_OFF_IRQ_STAT) begin
            next_irq_stat = '0;
        end
        next_irq_stat = next_irq_stat | irq_evt;
    end

    // reset restores the idle defaults
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            ctrl <= `BPMC_CTRL_RST;
            bsf <= 1'b0;
            battery_low_flag <= 1'b0;
            irq_stat <= '0;
            irq_mask <= `BPMC_IRQ_MASK_RST;
            ts_time <= '0;
            rdata <= 32'h0;
            ts_pulse <= 1'b0;
        end else begin
            ctrl <= next_ctrl;
            bsf <= next_bsf;
            battery_low_flag <= next_blf;
            irq_stat <= next_irq_stat;
            irq_mask <= next_irq_mask;
            ts_time <= next_ts_time;
            rdata <= next_rdata;
            ts_pulse <= next_ts_pulse;
        end
    end

    // -------------------------------------------------------------------------
    // outputs
    // -------------------------------------------------------------------------
    // with the switch bit masked, the switch interrupt needs the flag itself, so clearing it drops irq
    assign irq_o = |(irq_stat & irq_mask) |
        (bsf & ctrl[`BPMC_CTRL_BIE_BIT]);

    // register copies to pins
    assign reg_rdata_o = rdata;
    assign on_backup_o = backup;
    assign ts_capture_o = ts_pulse;

    // host interface dead on backup
    assign serial_in_gated_o = backup ? 4'h0 : serial_in_i;
    assign serial_out_o = backup ? 4'h0 : serial_out_i;
    assign serial_oe_o = backup ? 4'h0 : serial_oe_i;
    // open-drain active low: pulled low on backup, and on main when enabled and input under reference
    assign power_fail_out_o = 1'b0;
    assign power_fail_out_oe_o = backup |
        ((state == bpmc_pkg::BPMC_ST_MAIN) & cmp.func.pfail_en & cmp.pfi_low);
endmodule : bpmc_power_ctrl

// [pkg/bpmc_defs.svh]
// constants for the backup power mode control block: offsets, field positions,
// reset values and timing counts.
// assumes inclusion by bare name from package and design files.
`ifndef BPMC_DEFS_SVH
`define BPMC_DEFS_SVH

// -----------------------------------------------------------------------------
// register offsets (one step per 32-bit register on the plain register port)
// -----------------------------------------------------------------------------
`define BPMC_ADDR_W 4
`define BPMC_OFF_CTRL 4'h0
`define BPMC_OFF_STATUS 4'h1
`define BPMC_OFF_IRQ_STAT 4'h2
`define BPMC_OFF_IRQ_MASK 4'h3
`define BPMC_OFF_TS_TIME 4'h4

// -----------------------------------------------------------------------------
// control register fields
// -----------------------------------------------------------------------------
`define BPMC_CTRL_SEL_LSB 0
`define BPMC_CTRL_SEL_MSB 2
`define BPMC_CTRL_BIE_BIT 3
`define BPMC_CTRL_BATTERY_SWITCH_TIMESTAMP_ENABLE_BIT 4
`define BPMC_CTRL_RST 8'h00

// -----------------------------------------------------------------------------
// status register fields
// -----------------------------------------------------------------------------
`define BPMC_ST_BSF_BIT 0
`define BPMC_ST_BLF_BIT 1
`define BPMC_ST_BACKUP_BIT 2
`define BPMC_ST_PFO_BIT 3
`define BPMC_ST_CLR_BSF_BIT 0

// -----------------------------------------------------------------------------
// interrupt status / mask fields (same layout)
// -----------------------------------------------------------------------------
`define BPMC_IRQ_W 3
`define BPMC_IRQ_SWITCH_BIT 0
`define BPMC_IRQ_BATLOW_BIT 1
`define BPMC_IRQ_RETURN_BIT 2
`define BPMC_IRQ_MASK_RST 3'h0

// -----------------------------------------------------------------------------
// timing: power fail comparator recovery after return to main supply
// -----------------------------------------------------------------------------
`define BPMC_CLK_HZ 10000000
`define BPMC_T_REC_US 15630
`define BPMC_REC_CYCLES ((`BPMC_T_REC_US * (`BPMC_CLK_HZ / 1000000) + 0))
`define BPMC_TIME_W 32

`endif

// [pkg/bpmc_pkg.sv]
// types for the backup power mode control block.
// assumes bpmc_defs.svh sits on the include path.
`include "bpmc_defs.svh"

package bpmc_pkg;

    // switch-over operating mode
    typedef enum logic [1:0] {
        BPMC_MODE_STANDARD,
        BPMC_MODE_DIRECT,
        BPMC_MODE_DISABLED
    } bpmc_mode_t;

    // decoded power function selection
    typedef struct packed {
        bpmc_mode_t mode;
        logic batlow_en;
        logic pfail_en;
    } bpmc_func_t;

    // supply state machine
    typedef enum logic [1:0] {
        BPMC_ST_MAIN,
        BPMC_ST_BACKUP,
        BPMC_ST_RECOVER
    } bpmc_state_t;

endpackage : bpmc_pkg

// [pkg/bpmc_cmp_if.sv]
// interface carrying synchronised comparator results and decoded function
// between the main block and its helper modules.
// assumes one clock domain, core_clk_i.
`timescale 1ns/1ps

interface bpmc_cmp_if;
    logic vdd_lt_bat;
    logic vdd_lt_thr;
    logic bat_low;
    logic pfi_low;
    logic [2:0] sel;
    bpmc_pkg::bpmc_func_t func;
    logic pfail_cond;

    modport decoder (
        input sel,
        output func
    );
    modport judge (
        input vdd_lt_bat,
        input vdd_lt_thr,
        input func,
        output pfail_cond
    );
    modport top (
        output vdd_lt_bat,
        output vdd_lt_thr,
        output sel,
        input func,
        input pfail_cond,
        output bat_low,
        output pfi_low
    );
endinterface : bpmc_cmp_if

// [src/bpmc_func_decode.sv]
// decoder of the 3-bit power function selection into mode and enables.
// assumes a selection value registered on core_clk_i.
`timescale 1ns/1ps

module bpmc_func_decode (
    bpmc_cmp_if.decoder cmp
);
    // -------------------------------------------------------------------------
    // selection table
    // -------------------------------------------------------------------------
    // decode is purely combinational; the selection register already holds it
    always_comb begin
        cmp.func.mode = bpmc_pkg::BPMC_MODE_STANDARD;
        cmp.func.batlow_en = 1'b0;
        cmp.func.pfail_en = 1'b0;
        case (cmp.sel)
            3'h0: begin
                cmp.func.batlow_en = 1'b1;
                cmp.func.pfail_en = 1'b1;
            end
            3'h1: cmp.func.pfail_en = 1'b1;
            3'h2: cmp.func.pfail_en = 1'b0;
            3'h3: begin
                cmp.func.mode = bpmc_pkg::BPMC_MODE_DIRECT;
                cmp.func.batlow_en = 1'b1;
                cmp.func.pfail_en = 1'b1;
            end
            3'h4: begin
                cmp.func.mode = bpmc_pkg::BPMC_MODE_DIRECT;
                cmp.func.pfail_en = 1'b1;
            end
            3'h5: cmp.func.mode = bpmc_pkg::BPMC_MODE_DIRECT;
            3'h6: begin
                cmp.func.mode = bpmc_pkg::BPMC_MODE_DISABLED;
                cmp.func.pfail_en = 1'b1;
            end
            default: cmp.func.mode = bpmc_pkg::BPMC_MODE_DISABLED;
        endcase
        // low-battery detection cannot survive a disabled switch-over
        if (cmp.func.mode == bpmc_pkg::BPMC_MODE_DISABLED) begin
            cmp.func.batlow_en = 1'b0;
        end
    end
endmodule : bpmc_func_decode

// [src/bpmc_fail_judge.sv]
// power failure condition from synchronised supply comparator results.
// assumes comparator levels already pass a two-flop synchroniser.
`timescale 1ns/1ps

module bpmc_fail_judge (
    bpmc_cmp_if.judge cmp
);
    // -------------------------------------------------------------------------
    // failure condition per mode
    // -------------------------------------------------------------------------
    always_comb begin
        case (cmp.func.mode)
            bpmc_pkg::BPMC_MODE_STANDARD: cmp.pfail_cond = cmp.vdd_lt_bat & cmp.vdd_lt_thr;
            bpmc_pkg::BPMC_MODE_DIRECT: cmp.pfail_cond = cmp.vdd_lt_bat;
            default: cmp.pfail_cond = 1'b0;
        endcase
    end
endmodule : bpmc_fail_judge

// [verification/bpmc_power_chk.sv]
// port checker for the backup power mode control block
// assumes it is bound onto bpmc_power_ctrl, one clock, sync reset
`timescale 1ns/1ps
`include "bpmc_defs.svh"

module bpmc_power_chk #(
    parameter int unsigned REC_CYCLES = `BPMC_REC_CYCLES
) (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic [`BPMC_ADDR_W-1:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [31:0] reg_rdata_o,
    input wire logic vdd_below_bat_i,
    input wire logic vdd_below_thr_i,
    input wire logic [3:0] serial_in_gated_o,
    input wire logic [3:0] serial_out_o,
    input wire logic [3:0] serial_oe_o,
    input wire logic on_backup_o,
    input wire logic power_fail_out_o,
    input wire logic power_fail_out_oe_o,
    input wire logic ts_capture_o,
    input wire logic irq_o
);
    logic [2:0] sel_q;
    logic bie_q;

    // shadow of the selection; writes made on backup never land
    always_ff @(posedge core_clk_i) begin
        if (rst_i) begin
            sel_q <= 3'h0;
            bie_q <= 1'b0;
        end else if (reg_wr_i && !on_backup_o && reg_addr_i == `BPMC_OFF_CTRL) begin
            sel_q <= reg_wdata_i[2:0];
            bie_q <= reg_wdata_i[`BPMC_CTRL_BIE_BIT];
        end
    end

    // ----------------------------------------------------------------
    // properties
    // ----------------------------------------------------------------
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (rst_i);

    // six cycles cover the two sync flops and the state update
    sequence s_std_both; (sel_q <= 3'h2 && vdd_below_bat_i && vdd_below_thr_i)[*6]; endsequence
    sequence s_std_bat; (sel_q <= 3'h2 && vdd_below_bat_i && !vdd_below_thr_i)[*6]; endsequence
    sequence s_dir_bat; (sel_q >= 3'h3 && sel_q <= 3'h5 && vdd_below_bat_i)[*6]; endsequence

    a_std_switch_on: assert property (s_std_both |-> on_backup_o)
        else $error("standard mode stayed on main supply");
    a_std_thr_guard: assert property (s_std_bat |-> !on_backup_o)
        else $error("standard mode switched above threshold");
    a_direct_switch: assert property (s_dir_bat |-> on_backup_o)
        else $error("direct mode stayed on main supply");
    a_disabled_main: assert property ((sel_q >= 3'h6)[*2] |-> !on_backup_o)
        else $error("switch-over while disabled");
    a_backup_gates_in: assert property (on_backup_o |-> serial_in_gated_o == 4'h0)
        else $error("serial input passed while on backup");
    a_backup_hiz_out: assert property (on_backup_o |-> (serial_oe_o | serial_out_o) == 4'h0)
        else $error("serial output driven while on backup");
    a_backup_pfo_low: assert property (on_backup_o |-> power_fail_out_oe_o && !power_fail_out_o)
        else $error("power fail pin not held low on backup");
    a_read_blocked: assert property (on_backup_o && reg_rd_i |=> reg_rdata_o == 32'h0)
        else $error("register read answered on backup");
    a_entry_irq: assert property ($rose(on_backup_o) && bie_q |-> irq_o)
        else $error("no switch interrupt on entry");
    a_entry_stamp: assert property (ts_capture_o |-> $rose(on_backup_o))
        else $error("timestamp capture outside entry");
endmodule : bpmc_power_chk

bind bpmc_power_ctrl bpmc_power_chk #(.REC_CYCLES(REC_CYCLES)) u_chk (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .vdd_below_bat_i(vdd_below_bat_i),
    .vdd_below_thr_i(vdd_below_thr_i), .serial_in_gated_o(serial_in_gated_o),
    .serial_out_o(serial_out_o), .serial_oe_o(serial_oe_o), .on_backup_o(on_backup_o),
    .power_fail_out_o(power_fail_out_o), .power_fail_out_oe_o(power_fail_out_oe_o),
    .ts_capture_o(ts_capture_o), .irq_o(irq_o));

// [verification/bpmc_host_model.sv]
// host model: master of the plain register port
// assumes the block answers a read in the next cycle and never stalls
`timescale 1ns/1ps
`include "bpmc_defs.svh"

module bpmc_host_model (
    input wire logic core_clk_i,
    input wire logic [31:0] reg_rdata_i,
    output logic [`BPMC_ADDR_W-1:0] reg_addr_o,
    output logic [31:0] reg_wdata_o,
    output logic reg_wr_o,
    output logic reg_rd_o
);
    // ----------------------------------------------------------------
    // bus cycles
    // ----------------------------------------------------------------
    initial begin
        reg_addr_o = 4'h0;
        reg_wdata_o = 32'h0;
        reg_wr_o = 1'b0;
        reg_rd_o = 1'b0;
    end

    // one-cycle write; the strobe drops before any next access starts
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge core_clk_i);
        reg_addr_o <= a;
        reg_wdata_o <= d;
        reg_wr_o <= 1'b1;
        @(posedge core_clk_i);
        reg_wr_o <= 1'b0;
    endtask : wr

    // one-cycle read; data stand only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge core_clk_i);
        reg_addr_o <= a;
        reg_rd_o <= 1'b1;
        @(posedge core_clk_i);
        reg_rd_o <= 1'b0;
        #1;
        d = reg_rdata_i;
    endtask : rd
endmodule : bpmc_host_model

// [verification/testbench.sv]
// self-checking bench for the backup power mode control block
// assumes the host model drives the register port
`timescale 1ns/1ps
`include "bpmc_defs.svh"

module testbench;
    localparam int unsigned REC = 8;
    logic core_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [3:0] addr;
    logic [31:0] wdata, rdata, rv;
    logic wr, rd, battery_switch_irq_enable, battery_switch_timestamp_enable;
    logic bat = 1'b0, thr = 1'b0, blow = 1'b0, pfi = 1'b0;
    logic [31:0] tnow = 32'h0;
    logic [3:0] sin = 4'h0, sout = 4'h0, soe = 4'h0;
    logic [3:0] sin_g, sout_g, soe_g;
    logic backup, power_fail_out, pfo_oe, tsc, irq;
    int err_count = 0;
    int n_tests = 0;
    int tsn = 0;
    int tsn0 = 0;
    logic [31:0] tsv = 32'h0;

    always #50 core_clk_i = ~core_clk_i;
    always @(posedge core_clk_i) tnow <= tnow + 32'h1;
    always @(posedge core_clk_i) if (tsc === 1'b1) tsn <= tsn + 1;
    always @(posedge core_clk_i) if (tsc === 1'b1) tsv <= tnow - 32'h1;

    bpmc_host_model host (.core_clk_i(core_clk_i), .reg_rdata_i(rdata), .reg_addr_o(addr),
        .reg_wdata_o(wdata), .reg_wr_o(wr), .reg_rd_o(rd));

    // short recovery count keeps each switch-over loop brief
    bpmc_power_ctrl #(.REC_CYCLES(REC)) DUT (.core_clk_i(core_clk_i), .rst_i(rst_i),
        .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
        .reg_rdata_o(rdata), .vdd_below_bat_i(bat), .vdd_below_thr_i(thr),
        .bat_below_low_i(blow), .pfi_below_ref_i(pfi), .time_now_i(tnow),
        .serial_in_i(sin), .serial_in_gated_o(sin_g), .serial_out_i(sout),
        .serial_oe_i(soe), .serial_out_o(sout_g), .serial_oe_o(soe_g),
        .on_backup_o(backup), .power_fail_out_o(power_fail_out), .power_fail_out_oe_o(pfo_oe),
        .ts_capture_o(tsc), .irq_o(irq));

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic f_switch(input logic [2:0] s, input logic b, input logic t);
        return (s <= 3'h2) ? (b & t) : ((s <= 3'h5) ? b : 1'b0);
    endfunction : f_switch

    function automatic logic f_pf(input logic [2:0] s);
        return s inside {3'h0, 3'h1, 3'h3, 3'h4, 3'h6};
    endfunction : f_pf

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask : check

    // comparator levels and random serial traffic change at an edge
    task automatic drive(input logic b, input logic t, input logic l, input logic p);
        @(posedge core_clk_i);
        bat <= b;
        thr <= t;
        blow <= l;
        pfi <= p;
        sin <= 4'($urandom);
        sout <= 4'($urandom);
        soe <= 4'($urandom);
    endtask : drive

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge core_clk_i);
        #1;
    endtask : wait_cyc

    task automatic report_and_stop;
        $display("comparisons %0d, mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : report_and_stop

    // hang guard: far above the length of the whole sequence
    initial begin
        repeat (20000) @(posedge core_clk_i);
        err_count++;
        report_and_stop();
    end

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        logic [2:0] s;
        void'($urandom(32'hF8F2));
        repeat (2) @(posedge core_clk_i);
        rst_i <= 1'b0;
        wait_cyc(1);
        host.rd(`BPMC_OFF_CTRL, rv);
        check("ctrl reset", 32'h0, rv);
        host.rd(`BPMC_OFF_IRQ_MASK, rv);
        check("mask reset", 32'h0, rv);
        for (int i = 0; i < 8; i++) begin
            s = 3'(i);
            battery_switch_irq_enable = 1'($urandom);
            battery_switch_timestamp_enable = 1'($urandom);
            host.rd(`BPMC_OFF_IRQ_STAT, rv);
            host.wr(`BPMC_OFF_CTRL, {27'h0, battery_switch_timestamp_enable, battery_switch_irq_enable, s});
            drive(1'b1, 1'b0, 1'b0, 1'b0);
            tsn0 = tsn;
            wait_cyc(6);
            check("backup above thr", 32'(f_switch(s, 1'b1, 1'b0)), 32'(backup));
            drive(1'b1, 1'b1, 1'b0, 1'b0);
            wait_cyc(6);
            check("backup below thr", 32'(f_switch(s, 1'b1, 1'b1)), 32'(backup));
            check("switch irq", 32'(s <= 3'h5 && battery_switch_irq_enable), 32'(irq));
            check("stamp pulses", 32'(s <= 3'h5 && battery_switch_timestamp_enable), 32'(tsn - tsn0));
            if (s <= 3'h5) begin
                check("gated input", 32'h0, 32'(sin_g));
                check("serial enable", 32'h0, 32'(soe_g));
                check("pfo on backup", 32'h1, 32'(pfo_oe));
                check("serial out", 32'h0, 32'(sout_g));
                host.rd(`BPMC_OFF_STATUS, rv);
                check("blocked read", 32'h0, rv);
                host.wr(`BPMC_OFF_CTRL, 32'h7);
            end
            drive(1'b0, 1'b0, 1'b0, 1'b0);
            wait_cyc(REC + 8);
            host.rd(`BPMC_OFF_IRQ_STAT, rv);
            check("irq events", {29'h0, (s <= 3'h5), 1'b0, (s <= 3'h5 && battery_switch_irq_enable)}, rv);
            host.rd(`BPMC_OFF_TS_TIME, rv);
            if (s <= 3'h5 && battery_switch_timestamp_enable) check("stamp time", tsv, rv);
            host.rd(`BPMC_OFF_CTRL, rv);
            check("ctrl kept", {27'h0, battery_switch_timestamp_enable, battery_switch_irq_enable, s}, rv);
            host.rd(`BPMC_OFF_STATUS, rv);
            check("switch flag", 32'(s <= 3'h5), {31'h0, rv[0]});
            host.wr(`BPMC_OFF_STATUS, 32'h1);
            host.rd(`BPMC_OFF_STATUS, rv);
            check("flag cleared", 32'h0, {31'h0, rv[0]});
            check("irq after clear", 32'h0, 32'(irq));
            drive(1'b0, 1'b0, 1'b1, 1'b1);
            wait_cyc(4);
            check("pfo detect", 32'(f_pf(s)), 32'(pfo_oe));
            check("input passed", 32'(sin), 32'(sin_g));
            check("output passed", {24'h0, sout, soe}, {24'h0, sout_g, soe_g});
            host.wr(`BPMC_OFF_STATUS, 32'h2);
            host.rd(`BPMC_OFF_STATUS, rv);
            check("battery low", 32'(s == 3'h0 || s == 3'h3), {31'h0, rv[1]});
            drive(1'b0, 1'b0, 1'b0, 1'b0);
            wait_cyc(4);
            host.rd(`BPMC_OFF_STATUS, rv);
            check("battery good", 32'h0, {31'h0, rv[1]});
        end
        // masked and unmasked battery low interrupt, cleared by reading
        host.wr(`BPMC_OFF_CTRL, 32'h0);
        host.wr(`BPMC_OFF_IRQ_MASK, 32'h2);
        host.rd(`BPMC_OFF_IRQ_STAT, rv);
        drive(1'b0, 1'b0, 1'b1, 1'b0);
        wait_cyc(4);
        check("low irq", 32'h1, 32'(irq));
        host.rd(`BPMC_OFF_IRQ_STAT, rv);
        check("irq status", 32'h2, rv);
        check("irq read clear", 32'h0, 32'(irq));
        host.wr(`BPMC_OFF_IRQ_MASK, 32'h0);
        drive(1'b0, 1'b0, 1'b0, 1'b0);
        wait_cyc(4);
        drive(1'b0, 1'b0, 1'b1, 1'b0);
        wait_cyc(4);
        check("masked irq", 32'h0, 32'(irq));
        host.rd(4'hF, rv);
        check("unmapped read", 32'h0, rv);
        report_and_stop();
    end
endmodule : testbench
